// [src/ubs_pkg.sv]
// Constants, register map and state encodings for the serial status-two block.
// Assumes a 32-bit classic Wishbone bus with word addressing.
package ubs_pkg;

    // Register word indices; byte address is four times the index.
    localparam logic [5:0] IDX_S2 = 6'h05;
    localparam logic [5:0] IDX_CTRL = 6'h08;
    localparam logic [5:0] IDX_STAT = 6'h09;
    localparam logic [5:0] IDX_DATA = 6'h0A;
    localparam logic [5:0] IDX_IST = 6'h0B;
    localparam logic [5:0] IDX_IMSK = 6'h0C;

    // Fields of serial_status_two.
    localparam int S2_BRK = 7;
    localparam int S2_EDGE = 6;
    localparam int S2_RSVD = 5;
    localparam int S2_INV = 4;
    localparam int S2_IDLERPT = 3;
    localparam int S2_LONGSEND = 2;
    localparam int S2_LONGDET = 1;
    localparam int S2_RAF = 0;

    // Fields of the control, status and interrupt registers.
    localparam int CTRL_DATA9 = 0;
    localparam int CTRL_STOP2 = 1;
    localparam int CTRL_STANDBY = 2;
    localparam int CTRL_SENDBRK = 3;
    localparam int STAT_FULL = 0;
    localparam int STAT_FE = 1;
    localparam int STAT_IDLE = 2;
    localparam int IRQ_BRK = 0;
    localparam int IRQ_EDGE = 1;
    localparam int IRQ_IDLE = 2;
    localparam int IRQ_FULL = 3;

    // Reset values.
    localparam logic [7:0] RST_S2 = 8'h00;
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [3:0] RST_IMSK = 4'h0;

    // Bit-time counts.
    localparam logic [3:0] BASE_FRAME_BITS = 4'hA;
    localparam logic [3:0] LONG_SEND_EXTRA = 4'h3;
    localparam logic [3:0] DATA8_BITS = 4'h8;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_FRAME,
        RX_HOLD
    } ubs_rx_state_t;

    // Character length in bit times: start, data and stop bits.
    function automatic logic [3:0] frame_bits(input logic data9,
                                              input logic stop2);
        return BASE_FRAME_BITS + {3'h0, data9} + {3'h0, stop2};
    endfunction : frame_bits

endpackage : ubs_pkg

// [src/ubs_status_two.sv]
// Serial port status-two register with break, edge, idle and receiver logic.
// Assumes a classic Wishbone master and a receive pin synchronous to clk_i.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module ubs_status_two #(
    parameter int BIT_CLKS = 87
) (
    // Clock, reset and freeze.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Serial line and interrupt.
    input wire logic rx_i,
    output logic tx_o,
    output logic irq_o
);

    localparam logic [15:0] BIT_M1 = 16'(BIT_CLKS - 1);
    localparam logic [15:0] HALF_M1 = 16'(BIT_CLKS / 2 - 1);

    typedef struct packed {
        logic [7:0] s2;
        logic [2:0] ctrl;
        logic full;
        logic fe;
        logic idle;
        logic fe_pend;
        logic [8:0] rx_data;
        logic [8:0] rx_shift;
        logic [3:0] ist;
        logic [3:0] imsk;
        ubs_pkg::ubs_rx_state_t rx_st;
        logic rx_prev;
        logic [15:0] rx_baud;
        logic [3:0] rx_bitn;
        logic [3:0] lowrun;
        logic [3:0] idle_bits;
        logic idle_done;
        logic tx_line;
        logic [3:0] tx_bits;
        logic [15:0] tx_baud;
        logic ack;
        logic [31:0] dat;
    } ubs_state_t;

    ubs_state_t st_q;
    ubs_state_t st_d;

    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic wr_s2;
    logic rx_int;
    logic fall;
    logic data9;
    logic stop2;
    logic long_det;
    logic [3:0] fbits;
    logic [3:0] thr;
    logic [3:0] dlen;
    logic [3:0] lastbit;
    logic [3:0] low_new;
    logic bit_v;
    logic brk_hit;
    logic [31:0] rdata;

    assign req = cyc_i & stb_i;
    // Effects happen on the edge where the master samples ack high.
    assign acc = req & st_q.ack;
    assign wr = acc & we_i & sel_i[0];
    assign rd = acc & ~we_i;
    assign wr_s2 = wr && (adr_i == ubs_pkg::IDX_S2);
    assign rx_int = rx_i ^ st_q.s2[ubs_pkg::S2_INV];
    // Falling edge of the corrected line is the active edge.
    assign fall = st_q.rx_prev & ~rx_int;
    assign data9 = st_q.ctrl[ubs_pkg::CTRL_DATA9];
    assign stop2 = st_q.ctrl[ubs_pkg::CTRL_STOP2];
    assign long_det = st_q.s2[ubs_pkg::S2_LONGDET];
    assign fbits = ubs_pkg::frame_bits(data9, stop2);
    assign thr = fbits + {3'h0, long_det};
    assign dlen = ubs_pkg::DATA8_BITS + {3'h0, data9};
    assign lastbit = fbits - 4'h2;
    assign bit_v = rx_int;
    assign low_new = bit_v ? 4'h0 : st_q.lowrun + {3'h0, st_q.lowrun != 4'hF};
    assign brk_hit = ~bit_v && (low_new == thr) && (st_q.lowrun != thr);

    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_i)
            ubs_pkg::IDX_S2: rdata[7:0] = st_q.s2 & 8'hDF;
            ubs_pkg::IDX_CTRL: rdata[3:0] = {st_q.tx_bits != 4'h0, st_q.ctrl};
            ubs_pkg::IDX_STAT: rdata[2:0] = {st_q.idle, st_q.fe, st_q.full};
            ubs_pkg::IDX_DATA: rdata[8:0] = st_q.rx_data;
            ubs_pkg::IDX_IST: rdata[3:0] = st_q.ist;
            ubs_pkg::IDX_IMSK: rdata[3:0] = st_q.imsk;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_d = st_q;
        // Bus handshake: ack one cycle after the request, then drop.
        st_d.ack = req & ~st_q.ack;
        if (req && !st_q.ack) begin
            st_d.dat = rdata;
        end

        // Software writes and clears first; hardware sets below win.
        if (wr_s2) begin
            if (dat_i[ubs_pkg::S2_BRK]) begin
                st_d.s2[ubs_pkg::S2_BRK] = 1'b0;
            end
            if (dat_i[ubs_pkg::S2_EDGE]) begin
                st_d.s2[ubs_pkg::S2_EDGE] = 1'b0;
            end
            st_d.s2[4:1] = dat_i[4:1];
        end
        if (wr && adr_i == ubs_pkg::IDX_CTRL) begin
            st_d.ctrl = dat_i[2:0];
        end
        if (wr && adr_i == ubs_pkg::IDX_IMSK) begin
            st_d.imsk = dat_i[3:0];
        end
        if (rd && adr_i == ubs_pkg::IDX_IST) begin
            st_d.ist = 4'h0;
        end
        if (rd && adr_i == ubs_pkg::IDX_DATA) begin
            st_d.full = 1'b0;
            st_d.fe = 1'b0;
            st_d.idle = 1'b0;
        end

        st_d.rx_prev = rx_int;
        if (fall) begin
            st_d.s2[ubs_pkg::S2_EDGE] = 1'b1;
            st_d.ist[ubs_pkg::IRQ_EDGE] = 1'b1;
        end

        case (st_q.rx_st)
            ubs_pkg::RX_IDLE: begin
                if (fall) begin
                    st_d.rx_st = ubs_pkg::RX_START;
                    st_d.rx_baud = HALF_M1;
                end else if (!rx_int) begin
                    st_d.rx_baud = BIT_M1;
                    st_d.idle_bits = 4'h0;
                    st_d.idle_done = 1'b0;
                end else if (st_q.rx_baud != 16'h0000) begin
                    st_d.rx_baud = st_q.rx_baud - 16'h0001;
                end else begin
                    st_d.rx_baud = BIT_M1;
                    if (!st_q.idle_done) begin
                        st_d.idle_bits = st_q.idle_bits + 4'h1;
                        if (st_q.idle_bits + 4'h1 == fbits) begin
                            st_d.idle_done = 1'b1;
                            if (st_q.s2[ubs_pkg::S2_RAF]) begin
                                st_d.s2[ubs_pkg::S2_RAF] = 1'b0;
                                if (!st_q.ctrl[ubs_pkg::CTRL_STANDBY] ||
                                    st_q.s2[ubs_pkg::S2_IDLERPT]) begin
                                    st_d.idle = 1'b1;
                                    st_d.ist[ubs_pkg::IRQ_IDLE] = 1'b1;
                                end
                                // The idle character wakes the receiver.
                                st_d.ctrl[ubs_pkg::CTRL_STANDBY] = 1'b0;
                            end
                        end
                    end
                end
            end
            ubs_pkg::RX_START: begin
                if (st_q.rx_baud != 16'h0000) begin
                    st_d.rx_baud = st_q.rx_baud - 16'h0001;
                end else if (!rx_int) begin
                    st_d.s2[ubs_pkg::S2_RAF] = 1'b1;
                    st_d.rx_st = ubs_pkg::RX_FRAME;
                    st_d.rx_baud = BIT_M1;
                    st_d.rx_bitn = 4'h0;
                    st_d.lowrun = 4'h1;
                    st_d.fe_pend = 1'b0;
                    st_d.rx_shift = 9'h000;
                end else begin
                    // A glitch shorter than half a bit is not a start.
                    st_d.rx_st = ubs_pkg::RX_IDLE;
                    st_d.rx_baud = BIT_M1;
                end
            end
            ubs_pkg::RX_FRAME: begin
                if (st_q.rx_baud != 16'h0000) begin
                    st_d.rx_baud = st_q.rx_baud - 16'h0001;
                end else begin
                    st_d.rx_baud = BIT_M1;
                    st_d.rx_bitn = st_q.rx_bitn + 4'h1;
                    st_d.lowrun = low_new;
                    if (st_q.rx_bitn < dlen) begin
                        st_d.rx_shift = {bit_v, st_q.rx_shift[8:1]};
                    end else if (!bit_v) begin
                        st_d.fe_pend = 1'b1;
                    end
                    if (st_q.rx_bitn == lastbit) begin
                        // The long send select plays no part here.
                        if (!long_det) begin
                            st_d.full = 1'b1;
                            st_d.fe = st_d.fe_pend | st_q.fe;
                            st_d.ist[ubs_pkg::IRQ_FULL] = 1'b1;
                            st_d.rx_data = data9 ? st_q.rx_shift :
                                {1'b0, st_q.rx_shift[8:1]};
                        end
                        st_d.idle_bits = 4'h0;
                        st_d.idle_done = 1'b0;
                        st_d.rx_st = (low_new == fbits) ?
                            ubs_pkg::RX_HOLD : ubs_pkg::RX_IDLE;
                    end
                end
            end
            ubs_pkg::RX_HOLD: begin
                if (rx_int) begin
                    st_d.rx_st = ubs_pkg::RX_IDLE;
                    st_d.rx_baud = BIT_M1;
                end else if (st_q.rx_baud != 16'h0000) begin
                    st_d.rx_baud = st_q.rx_baud - 16'h0001;
                end else begin
                    st_d.rx_baud = BIT_M1;
                    st_d.lowrun = low_new;
                end
            end
            default: begin
                st_d.rx_st = ubs_pkg::RX_IDLE;
            end
        endcase

        // Break is counted at bit centres in the frame and hold states.
        if ((st_q.rx_st == ubs_pkg::RX_FRAME ||
             st_q.rx_st == ubs_pkg::RX_HOLD) &&
            st_q.rx_baud == 16'h0000 && brk_hit) begin
            st_d.ist[ubs_pkg::IRQ_BRK] = 1'b1;
            if (long_det) begin
                st_d.s2[ubs_pkg::S2_BRK] = 1'b1;
            end
        end

        // Break transmitter; a request while busy is ignored.
        if (st_q.tx_bits == 4'h0) begin
            if (wr && adr_i == ubs_pkg::IDX_CTRL &&
                dat_i[ubs_pkg::CTRL_SENDBRK]) begin
                st_d.tx_bits = fbits +
                    (st_q.s2[ubs_pkg::S2_LONGSEND] ?
                     ubs_pkg::LONG_SEND_EXTRA : 4'h0);
                st_d.tx_baud = BIT_M1;
            end
        end else if (st_q.tx_baud != 16'h0000) begin
            st_d.tx_baud = st_q.tx_baud - 16'h0001;
        end else begin
            st_d.tx_baud = BIT_M1;
            st_d.tx_bits = st_q.tx_bits - 4'h1;
        end
        st_d.tx_line = (st_d.tx_bits == 4'h0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.s2 <= ubs_pkg::RST_S2;
            st_q.ctrl <= ubs_pkg::RST_CTRL;
            st_q.imsk <= ubs_pkg::RST_IMSK;
            st_q.rx_prev <= 1'b1;
            st_q.tx_line <= 1'b1;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign dat_o = st_q.dat;
    assign ack_o = st_q.ack;
    assign tx_o = st_q.tx_line;
    assign irq_o = |(st_q.ist & st_q.imsk);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    brk_set_a: assert property (
        $rose(st_q.s2[ubs_pkg::S2_BRK]) |-> $past(long_det))
        else $error("break flag set while long detection off");
    brk_clear_a: assert property (
        $fell(st_q.s2[ubs_pkg::S2_BRK]) |->
            $past(wr_s2 && dat_i[ubs_pkg::S2_BRK] && ce_i))
        else $error("break flag cleared without a write of one");
    edge_set_a: assert property (
        (ce_i && fall) |=> st_q.s2[ubs_pkg::S2_EDGE])
        else $error("edge flag missed an active edge");
    edge_hold_a: assert property (
        $fell(st_q.s2[ubs_pkg::S2_EDGE]) |->
            $past(wr_s2 && dat_i[ubs_pkg::S2_EDGE] && ce_i))
        else $error("edge flag cleared without a write of one");
    rsvd_zero_a: assert property (
        (ce_i && req && !st_q.ack && adr_i == ubs_pkg::IDX_S2)
        |=> !dat_o[5])
        else $error("reserved bit read back as one");
    start_inv_a: assert property (
        (ce_i && st_q.rx_st == ubs_pkg::RX_IDLE &&
         st_q.rx_prev && (rx_i == st_q.s2[ubs_pkg::S2_INV]))
        |=> st_q.rx_st == ubs_pkg::RX_START)
        else $error("start edge not seen through inversion");
    idle_gate_a: assert property (
        $rose(st_q.idle) |-> $past(!st_q.ctrl[ubs_pkg::CTRL_STANDBY] ||
                                   st_q.s2[ubs_pkg::S2_IDLERPT]))
        else $error("idle flag set in standby without report");
    tx_len_a: assert property (
        $rose(st_q.tx_bits != 4'h0) |-> st_q.tx_bits ==
            $past(fbits) + ($past(st_q.s2[ubs_pkg::S2_LONGSEND]) ?
                            ubs_pkg::LONG_SEND_EXTRA : 4'h0))
        else $error("sent break length wrong");
    tx_low_a: assert property (
        (st_q.tx_bits != 4'h0) |-> !tx_o)
        else $error("line high during break");
    thr_a: assert property (
        $rose(st_q.ist[ubs_pkg::IRQ_BRK]) |->
            $past(low_new) == $past(thr) || $past(rd))
        else $error("break seen at wrong threshold");
    block_a: assert property (
        ($rose(st_q.full) || $rose(st_q.fe)) |-> !$past(long_det))
        else $error("full or framing flag set under long detection");
    raf_a: assert property (
        $rose(st_q.s2[ubs_pkg::S2_RAF]) |->
            $past(st_q.rx_st) == ubs_pkg::RX_START)
        else $error("active flag set without a start bit");
    ack_a: assert property (
        (ce_i && req && !st_q.ack) |=> ack_o ##1 !ack_o)
        else $error("bus answer not one cycle");
    brk_cov: cover property ($rose(st_q.s2[ubs_pkg::S2_BRK]));
    frame_cov: cover property ($rose(st_q.full));
    idle_cov: cover property ($fell(st_q.s2[ubs_pkg::S2_RAF]));
    txbrk_cov: cover property ($fell(st_q.tx_bits != 4'h0));

endmodule : ubs_status_two

`default_nettype wire

// [testbench/ubs_node.sv]
// Remote serial node: drives the receive line and times sent breaks.
// Assumes the bench calls its task from the clk_i domain.
`timescale 1ns/1ns
`default_nettype none
module ubs_node #(
    parameter int BIT_CLKS = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial line.
    input wire logic inv_i,
    input wire logic tx_i,
    output logic rx_o
);
    logic level_q = 1'b1;
    int low_q;
    int last_low;

    // An inverted link idles low on the wire.
    assign rx_o = level_q ^ inv_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_q <= 0;
            last_low <= 0;
        end else if (!tx_i) begin
            low_q <= low_q + 1;
        end else if (low_q != 0) begin
            last_low <= low_q;
            low_q <= 0;
        end
    end

    // Sends n bits LSB first, then returns the line to idle.
    task automatic send(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            level_q <= bits[i];
            repeat (BIT_CLKS - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        level_q <= 1'b1;
    endtask : send
endmodule : ubs_node
`default_nettype wire

// [testbench/test_uart_break_edge_status.sv]
// Self-checking bench for the serial status-two block.
// Assumes ubs_pkg and ubs_node are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_uart_break_edge_status;
    localparam int BT = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic inv = 1'b0;
    logic ce = 1'b1;
    wire logic [31:0] dat_o;
    wire logic ack_o;
    wire logic rx;
    wire logic tx;
    wire logic irq;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #50 clk_i = ~clk_i;

    ubs_status_two #(.BIT_CLKS(BT)) i_ubs_status_two (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .rx_i(rx), .tx_o(tx), .irq_o(irq));
    ubs_node #(.BIT_CLKS(BT)) i_ubs_node (.clk_i(clk_i), .rst_i(rst_i),
        .inv_i(inv), .tx_i(tx), .rx_o(rx));

    task automatic close_out();
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Classic single cycle; only the run timeout ends a missing ack.
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic idle(input int n);
        repeat (n * BT) @(posedge clk_i);
    endtask : idle

    task automatic t_fields();
        logic [31:0] q;
        rd(ubs_pkg::IDX_S2, q);
        check("s2_reset", q, 32'h0);
        rd(6'h3F, q);
        check("unmapped", q, 32'h0);
        wr(ubs_pkg::IDX_S2, 8'h20);
        rd(ubs_pkg::IDX_S2, q);
        check("s2_rsvd", q, 32'h0);
        wr(ubs_pkg::IDX_S2, 8'h2E);
        rd(ubs_pkg::IDX_S2, q);
        check("s2_ctrl", q, 32'h0E);
        wr(ubs_pkg::IDX_S2, 8'h00);
    endtask : t_fields

    task automatic t_frame();
        logic [31:0] q;
        wr(ubs_pkg::IDX_IMSK, 8'h02);
        fork
            i_ubs_node.send({7'h7F, 8'h55, 1'b0}, 10);
            begin
                idle(3);
                rd(ubs_pkg::IDX_S2, q);
                check("active", q[0], 1'b1);
            end
        join
        idle(14);
        rd(ubs_pkg::IDX_S2, q);
        check("edge_set", q, 32'h40);
        check("irq_up", irq, 1'b1);
        rd(ubs_pkg::IDX_DATA, q);
        check("data", q, 32'h55);
        wr(ubs_pkg::IDX_S2, 8'h00);
        rd(ubs_pkg::IDX_S2, q);
        check("edge_hold", q, 32'h40);
        wr(ubs_pkg::IDX_S2, 8'h40);
        rd(ubs_pkg::IDX_S2, q);
        check("edge_clr", q, 32'h0);
        rd(ubs_pkg::IDX_IST, q);
        check("int_stat", q, 32'h0E);
        @(posedge clk_i);
        check("irq_down", irq, 1'b0);
        wr(ubs_pkg::IDX_IMSK, 8'h00);
    endtask : t_frame

    task automatic t_invert();
        logic [31:0] q;
        wr(ubs_pkg::IDX_S2, 8'h10);
        inv <= 1'b1;
        idle(2);
        wr(ubs_pkg::IDX_S2, 8'h50);
        i_ubs_node.send({7'h7F, 8'hA3, 1'b0}, 10);
        idle(14);
        rd(ubs_pkg::IDX_S2, q);
        check("inv_edge", q, 32'h50);
        rd(ubs_pkg::IDX_DATA, q);
        check("inv_data", q, 32'hA3);
        wr(ubs_pkg::IDX_S2, 8'h00);
        inv <= 1'b0;
        idle(2);
        wr(ubs_pkg::IDX_S2, 8'h40);
        rd(ubs_pkg::IDX_IST, q);
    endtask : t_invert

    task automatic t_rx_break();
        logic [31:0] q;
        int thr;
        for (int c = 0; c < 8; c++) begin
            thr = 10 + c[0] + c[1] + c[2];
            wr(ubs_pkg::IDX_CTRL, {6'h0, c[1], c[0]});
            wr(ubs_pkg::IDX_S2, {6'h30, c[2], 1'b0});
            rd(ubs_pkg::IDX_IST, q);
            i_ubs_node.send(16'h0, thr - 1);
            idle(16);
            rd(ubs_pkg::IDX_DATA, q);
            rd(ubs_pkg::IDX_IST, q);
            check("brk_short", q[0], 1'b0);
            i_ubs_node.send(16'h0, thr);
            idle(16);
            rd(ubs_pkg::IDX_IST, q);
            check("brk_thr", q[0], 1'b1);
            rd(ubs_pkg::IDX_S2, q);
            check("brk_flag", q[7], c[2]);
            rd(ubs_pkg::IDX_STAT, q);
            if (c[2]) begin
                check("no_fe_full", q[1:0], 2'h0);
            end else begin
                check("fe_full", q[1:0], 2'h3);
            end
            rd(ubs_pkg::IDX_DATA, q);
        end
        wr(ubs_pkg::IDX_S2, 8'h02);
        rd(ubs_pkg::IDX_S2, q);
        check("brk_hold", q[7], 1'b1);
        wr(ubs_pkg::IDX_S2, 8'h82);
        rd(ubs_pkg::IDX_S2, q);
        check("brk_clr", q[7], 1'b0);
        wr(ubs_pkg::IDX_S2, 8'h40);
    endtask : t_rx_break

    task automatic t_tx_break();
        logic [31:0] q;
        int k;
        for (int c = 0; c < 8; c++) begin
            wr(ubs_pkg::IDX_S2, {5'h0, c[2], 2'h0});
            // The length follows the format already in force, so set it
            // before the send request.
            wr(ubs_pkg::IDX_CTRL, {6'h0, c[1], c[0]});
            wr(ubs_pkg::IDX_CTRL, {4'h0, 1'b1, 1'b0, c[1], c[0]});
            k = 0;
            do begin
                rd(ubs_pkg::IDX_CTRL, q);
                k++;
            end while (q[3] !== 1'b0 && k < 100);
            repeat (3) @(posedge clk_i);
            check("tx_len", i_ubs_node.last_low,
                  (10 + c[0] + c[1] + 3 * c[2]) * BT);
        end
        wr(ubs_pkg::IDX_CTRL, 8'h00);
    endtask : t_tx_break

    task automatic t_standby();
        logic [31:0] q;
        for (int r = 0; r < 2; r++) begin
            wr(ubs_pkg::IDX_S2, {4'h0, r[0], 3'h0});
            wr(ubs_pkg::IDX_CTRL, 8'h04);
            i_ubs_node.send({7'h7F, 8'h0F, 1'b0}, 10);
            idle(16);
            rd(ubs_pkg::IDX_STAT, q);
            check("idle_rpt", q[2], r[0]);
            rd(ubs_pkg::IDX_CTRL, q);
            check("woken", q[2], 1'b0);
            rd(ubs_pkg::IDX_DATA, q);
        end
    endtask : t_standby

    // A frozen block keeps its break going, so the far side sees it longer.
    task automatic t_freeze();
        logic [31:0] q;
        wr(ubs_pkg::IDX_S2, 8'h00);
        wr(ubs_pkg::IDX_CTRL, 8'h00);
        wr(ubs_pkg::IDX_CTRL, 8'h08);
        repeat (20) @(posedge clk_i);
        ce <= 1'b0;
        repeat (40) @(posedge clk_i);
        ce <= 1'b1;
        do begin
            rd(ubs_pkg::IDX_CTRL, q);
        end while (q[3] !== 1'b0);
        repeat (3) @(posedge clk_i);
        check("freeze", i_ubs_node.last_low, 10 * BT + 40);
    endtask : t_freeze

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_fields();
        t_frame();
        t_invert();
        t_rx_break();
        t_tx_break();
        t_standby();
        t_freeze();
        close_out();
    end
endmodule : test_uart_break_edge_status
`default_nettype wire
